// >>> src/ppm_pin_mux.sv
`timescale 1ns/100ps
// What this block does
// - any digital peripheral signal may route to port 0 or port 1 pins outside PPM_FIXED_PINS (p0.0-5,7,9-12,28-31, p1.0, p1.9)
// - each pin drives out at most one routed signal, lowest signal number wins; every signal selecting it reads its level
// - trace, analog, crystal, usb, swd, reset stay on fixed pins; analog on p0.2-5,28-31
// - reset input selectable only on port 0 pin 18, never on pin 21
// - instance 0 decodes window 0x40003000, instance 1 window 0x40004000
// - clearing then reconfiguring a window switches it to the new peripheral
module ppm_pin_mux
  import ppm_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [PPM_SIG_COUNT-1:0][PPM_SEL_W-1:0] sig_pin_sel,
  input ppm_pkg::ppm_sigs_t sig_drive,
  output logic [PPM_SIG_COUNT-1:0] sig_in,
  input ppm_pkg::ppm_pins_t port_drive,
  output logic [PPM_PIN_COUNT-1:0] port_in,
  input wire logic [PPM_PIN_COUNT-1:0] pad_in,
  output ppm_pkg::ppm_pins_t pad_drive,
  input wire logic reset_on_p18,
  output logic reset_in_n,
  output logic [7:0] analog_input_channels,
  input ppm_pkg::ppm_win_req_t win_req,
  output ppm_pkg::ppm_win_mode_t win0_mode,
  output ppm_pkg::ppm_win_mode_t win1_mode,
  output logic win_conflict
);
  typedef struct packed {
    ppm_pins_t pad;
    logic [PPM_PIN_COUNT-1:0] port_in;
    logic [PPM_SIG_COUNT-1:0] sig_in;
    logic reset_n;
    logic [7:0] analog;
  } ppm_mux_state_t;

  typedef struct packed {
    logic found;
    logic [PPM_SIG_W-1:0] idx;
  } ppm_claim_t;

  localparam ppm_mux_state_t MUX_RESET = '{
    pad: '0,
    port_in: '0,
    sig_in: '0,
    reset_n: 1'b1,
    analog: 8'h00
  };

  // registered outputs
  ppm_mux_state_t state;
  ppm_mux_state_t next_state;

  // per pin routing decision
  ppm_claim_t [PPM_PIN_COUNT-1:0] pin_claim;
  logic [PPM_PIN_COUNT-1:0] mux_out;
  logic [PPM_PIN_COUNT-1:0] mux_oe;
  logic [PPM_PIN_COUNT-1:0] hold_oe;

  // per signal input path
  logic [PPM_SIG_COUNT-1:0] sig_routed;
  logic [PPM_SIG_COUNT-1:0] sig_level;

  // fixed function pins
  logic reset_level_n;
  logic [7:0] analog_level;
  logic c0;
  logic c1;

  // pins that may take a routed signal
  function automatic logic [PPM_PIN_COUNT-1:0] routable_pins();
    logic [PPM_PIN_COUNT-1:0] m;
    m = '0;
    for (int p = 0; p < PPM_PIN_COUNT; p++) begin
      m[p] = !PPM_FIXED_PINS[p];
    end
    routable_pins = m;
  endfunction

  localparam logic [PPM_PIN_COUNT-1:0] ROUTABLE = routable_pins();

  // true when a select names a pin that may carry a routed signal
  function automatic logic pin_ok(input logic [PPM_SEL_W-1:0] sel);
    logic ok;
    ok = 1'b0;
    if (sel != PPM_SEL_NONE) begin
      if (int'(sel) < PPM_PIN_COUNT) begin
        ok = ROUTABLE[sel];
      end
    end
    pin_ok = ok;
  endfunction

  // true when a signal select claims the given pin
  function automatic logic sel_claims(input logic [PPM_SEL_W-1:0] sel, input int pin);
    sel_claims = pin_ok(sel) && (int'(sel) == pin);
  endfunction

  // lowest numbered claimant of a pin wins it
  function automatic ppm_claim_t first_claimant(input logic [PPM_SIG_COUNT-1:0][PPM_SEL_W-1:0] sels,
                                                input int pin);
    ppm_claim_t c;
    c = '{found: 1'b0, idx: '0};
    for (int s = PPM_SIG_COUNT - 1; s >= 0; s--) begin
      if (sel_claims(sels[s], pin)) begin
        c.found = 1'b1;
        c.idx = PPM_SIG_W'(s);
      end
    end
    first_claimant = c;
  endfunction

  // output side of every pin
  genvar gp;
  generate
    for (gp = 0; gp < PPM_PIN_COUNT; gp++) begin : g_pin
      always_comb begin
        pin_claim[gp] = first_claimant(sig_pin_sel, gp);
      end

      always_comb begin
        mux_out[gp] = port_drive.out[gp];
        if (pin_claim[gp].found) begin
          mux_out[gp] = sig_drive.out[pin_claim[gp].idx];
        end
      end

      always_comb begin
        mux_oe[gp] = port_drive.oe[gp];
        if (pin_claim[gp].found) begin
          mux_oe[gp] = sig_drive.oe[pin_claim[gp].idx];
        end
      end
    end
  endgenerate

  // input side of every peripheral signal
  genvar gs;
  generate
    for (gs = 0; gs < PPM_SIG_COUNT; gs++) begin : g_sig
      always_comb begin
        sig_routed[gs] = pin_ok(sig_pin_sel[gs]);
      end

      always_comb begin
        sig_level[gs] = 1'b0;
        if (sig_routed[gs]) begin
          sig_level[gs] = pad_in[sig_pin_sel[gs]];
        end
      end
    end
  endgenerate

  // reset function lives on pin 18 only
  always_comb begin
    hold_oe = '0;
    hold_oe[PPM_RESET_PIN] = reset_on_p18;
  end

  always_comb begin
    reset_level_n = 1'b1;
    if (reset_on_p18) begin
      reset_level_n = pad_in[PPM_RESET_PIN];
    end
  end

  // analog channels are hard wired
  always_comb begin
    analog_level = {pad_in[31:28], pad_in[5:2]};
  end

  // next register image
  always_comb begin
    next_state = state;
    next_state.pad.out = mux_out;
    next_state.pad.oe = mux_oe & ~hold_oe;
    next_state.port_in = pad_in;
    next_state.sig_in = sig_level;
    next_state.reset_n = reset_level_n;
    next_state.analog = analog_level;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state <= MUX_RESET;
    end else begin
      state <= next_state;
    end
  end

  // shared register window 0
  ppm_win_arbiter u_win0 (
    .sys_clk(sys_clk),
    .rst(rst),
    .req(win_req),
    .my_base(PPM_WIN0_BASE),
    .mode(win0_mode),
    .conflict(c0)
  );

  // shared register window 1
  ppm_win_arbiter u_win1 (
    .sys_clk(sys_clk),
    .rst(rst),
    .req(win_req),
    .my_base(PPM_WIN1_BASE),
    .mode(win1_mode),
    .conflict(c1)
  );

  // outputs
  assign win_conflict = c0 | c1;
  assign pad_drive = state.pad;
  assign port_in = state.port_in;
  assign sig_in = state.sig_in;
  assign reset_in_n = state.reset_n;
  assign analog_input_channels = state.analog;
endmodule // ppm_pin_mux

// >>> src/ppm_pkg.sv
package ppm_pkg;
  localparam int PPM_PIN_COUNT = 48;
  localparam int PPM_PORT0_PINS = 32;
  localparam int PPM_SIG_COUNT = 32;
  localparam int PPM_SEL_W = 6;
  localparam logic [5:0] PPM_SEL_NONE = 6'h3F;
  localparam int PPM_SIG_W = 5;
  localparam logic [31:0] PPM_WIN0_BASE = 32'h40003000;
  localparam logic [31:0] PPM_WIN1_BASE = 32'h40004000;
  localparam logic [31:0] PPM_WIN_MASK = 32'hFFFFF000;
  localparam int PPM_WIN_COUNT = 2;
  localparam logic [47:0] PPM_ANALOG_PINS = 48'h0000_F000_003C;
  localparam logic [47:0] PPM_FIXED_PINS = 48'h0201_F000_1EBF;
  localparam int PPM_RESET_PIN = 18;
  localparam int PPM_ALT_RESET_PIN = 21;

  typedef enum logic [1:0] {PPM_WIN_IDLE, PPM_WIN_SPI, PPM_WIN_TWI} ppm_win_mode_t;

  typedef struct packed {
    logic [PPM_PIN_COUNT-1:0] out;
    logic [PPM_PIN_COUNT-1:0] oe;
  } ppm_pins_t;

  typedef struct packed {
    logic [PPM_SIG_COUNT-1:0] out;
    logic [PPM_SIG_COUNT-1:0] oe;
  } ppm_sigs_t;

  typedef struct packed {
    logic en;
    logic [31:0] base;
    logic want_spi;
    logic want_twi;
  } ppm_win_req_t;
endpackage

// >>> src/ppm_win_arbiter.sv
`timescale 1ns/100ps
module ppm_win_arbiter
  import ppm_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input ppm_pkg::ppm_win_req_t req,
  input wire logic [31:0] my_base,
  output ppm_pkg::ppm_win_mode_t mode,
  output logic conflict
);
  typedef struct packed {
    ppm_win_mode_t mode;
    logic conflict;
  } ppm_arb_state_t;
  ppm_arb_state_t state;
  ppm_arb_state_t next_state;
  logic hit;
  always_comb begin
    next_state = state;
    hit = req.en && ((req.base & PPM_WIN_MASK) == my_base);
    if (hit) begin
      next_state.conflict = req.want_spi && req.want_twi;
      case ({req.want_spi, req.want_twi})
        2'b10: next_state.mode = PPM_WIN_SPI;
        2'b01: next_state.mode = PPM_WIN_TWI;
        default: next_state.mode = PPM_WIN_IDLE;
      endcase
    end
  end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state <= '{mode: PPM_WIN_IDLE, conflict: 1'b0};
    end else begin
      state <= next_state;
    end
  end
  assign mode = state.mode;
  assign conflict = state.conflict;
endmodule // ppm_win_arbiter

// >>> sim/ppm_pin_mux_props.sv
`timescale 1ns/100ps
module ppm_pin_mux_props
  import ppm_pkg::*;
(
  input logic sys_clk, rst, reset_on_p18, reset_in_n,
  input logic [31:0][5:0] sig_pin_sel,
  input ppm_pkg::ppm_sigs_t sig_drive,
  input ppm_pkg::ppm_pins_t pad_drive,
  input logic [47:0] pad_in,
  input logic [7:0] analog_input_channels,
  input ppm_pkg::ppm_win_req_t win_req,
  input ppm_pkg::ppm_win_mode_t win0_mode,
  input ppm_pkg::ppm_win_mode_t win1_mode,
  input logic win_conflict
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence s_w(bit s, t);
    win_req.en && win_req.base == PPM_WIN0_BASE && win_req.want_spi == s && win_req.want_twi == t;
  endsequence
  property p_an; 1 |=> analog_input_channels == $past({pad_in[31:28], pad_in[5:2]}); endproperty
  a_an: assert property (p_an) else $error("analog");
  property p_rs; reset_on_p18 |=> !pad_drive.oe[18] && reset_in_n == $past(pad_in[18]); endproperty
  a_rs: assert property (p_rs) else $error("reset pin");
  property p_rt; sig_pin_sel[0] == 6'h14 |=> pad_drive.oe[20] == $past(sig_drive.oe[0]); endproperty
  a_rt: assert property (p_rt) else $error("route");
  property p_sp; s_w(1, 0) |=> win0_mode == PPM_WIN_SPI; endproperty
  a_sp: assert property (p_sp) else $error("window");
  property p_sw; s_w(0, 0) ##1 s_w(0, 1) |=> win0_mode == PPM_WIN_TWI; endproperty
  a_sw: assert property (p_sw) else $error("switch");
  property p_cf;
    win_req.en && (win_req.base & PPM_WIN_MASK) == PPM_WIN1_BASE && win_req.want_spi && win_req.want_twi
      |=> win_conflict && win1_mode == PPM_WIN_IDLE;
  endproperty
  a_cf: assert property (p_cf) else $error("conflict");
endmodule // ppm_pin_mux_props
bind ppm_pin_mux ppm_pin_mux_props props (.*);

// >>> sim/ppm_pad_model.sv
`timescale 1ns/100ps
module ppm_pad_model
  import ppm_pkg::*;
(
  input logic sys_clk,
  input ppm_pkg::ppm_pins_t pad_drive,
  output logic [47:0] pad_in = '0
);
  // released pads show a fresh pattern
  always @(negedge sys_clk) pad_in <= pad_drive.oe & pad_drive.out | ~pad_drive.oe & 48'({$urandom, $urandom});
endmodule // ppm_pad_model

// >>> sim/tb.sv
`timescale 1ns/100ps
module tb;
  import ppm_pkg::*;
  logic sys_clk = 0, rst = 1, reset_on_p18 = 0, reset_in_n, win_conflict;
  logic [31:0][5:0] sig_pin_sel = '1;
  ppm_sigs_t sig_drive = '0;
  ppm_pins_t port_drive = '0, pad_drive, ep;
  ppm_win_req_t win_req = '0;
  ppm_win_mode_t win0_mode, win1_mode;
  logic [47:0] pad_in, port_in;
  logic [31:0] sig_in;
  logic [7:0] analog_input_channels;
  int err_count = 0, comparisons = 0, p;
  logic [47:0] e_port;
  logic [31:0] e_sig;
  logic [7:0] e_an;
  logic [31:0] wb [2] = '{PPM_WIN0_BASE, PPM_WIN1_BASE};
  ppm_win_mode_t em [2] = '{PPM_WIN_IDLE, PPM_WIN_IDLE};
  logic ec [2] = '{1'b0, 1'b0};
  ppm_pin_mux dut (.*);
  ppm_pad_model pads (.*);
  task automatic cmp(logic [95:0] g, e);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %0t bad", $time);
    end
  endtask
  task automatic cmp_mode(ppm_win_mode_t g, e);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %0t window mode", $time);
    end
  endtask
  task automatic summarize;
    if (err_count == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial forever #5 sys_clk = ~sys_clk;
  initial begin
    void'($urandom(32'hDFF9));
    repeat (8) @(negedge sys_clk);
    rst = 0;
    repeat (3000) begin
      #1;
      ep = port_drive;
      e_port = pad_in;
      e_sig = '0;
      e_an = {pad_in[31:28], pad_in[5:2]};
      foreach (sig_pin_sel[k]) begin
        p = sig_pin_sel[k];
        if (p < 48 && !PPM_FIXED_PINS[p]) begin
          {ep.oe[p], ep.out[p]} = {sig_drive.oe[k], sig_drive.out[k]};
          e_sig[k] = pad_in[p];
        end
      end
      ep.oe[18] &= !reset_on_p18;
      for (int w = 0; w < 2; w++) begin
        if (win_req.en && (win_req.base & PPM_WIN_MASK) == wb[w]) begin
          ec[w] = win_req.want_spi & win_req.want_twi;
          em[w] = win_req.want_spi ? PPM_WIN_SPI : PPM_WIN_TWI;
          if (win_req.want_spi == win_req.want_twi) em[w] = PPM_WIN_IDLE;
        end
      end
      @(negedge sys_clk);
      cmp(pad_drive, ep);
      cmp(reset_in_n, !reset_on_p18 | pad_in[18]);
      cmp(sig_in, e_sig);
      cmp(port_in, e_port);
      cmp(analog_input_channels, e_an);
      cmp(win_conflict, ec[0] | ec[1]);
      cmp_mode(win0_mode, em[0]);
      cmp_mode(win1_mode, em[1]);
      foreach (sig_pin_sel[k]) sig_pin_sel[k] = 6'($urandom);
      sig_drive = {$urandom, $urandom};
      port_drive = {$urandom, $urandom, $urandom};
      reset_on_p18 = 1'($urandom);
      win_req = {1'($urandom), 32'h40002000 + 32'h1000 * ($urandom % 3), 2'($urandom)};
    end
    summarize;
  end
endmodule // tb
